// [shared/ldpwm_defs.vh]
// Constants for the LED dimming PWM control block.
// Assumes a 10 MHz system clock and a digital front end that quantises
// the dimming input into a 10-bit level plus two comparator flags.
`ifndef LDPWM_DEFS_VH
`define LDPWM_DEFS_VH

// Register byte offsets on the APB bus.
`define LDPWM_ADDR_CTRL 12'h000
`define LDPWM_ADDR_STAT 12'h004
`define LDPWM_ADDR_IRQ 12'h008
`define LDPWM_ADDR_MASK 12'h00c
`define LDPWM_ADDR_RES 12'h010
`define LDPWM_ADDR_DUTY 12'h014

// Control register fields.
`define LDPWM_CTRL_EMB_EN 0
`define LDPWM_CTRL_DIG_EN 1
`define LDPWM_CTRL_RESET 32'h0000_0003

// Interrupt event bit positions.
`define LDPWM_EV_DIG_VALID 0
`define LDPWM_EV_DIG_REJECT 1
`define LDPWM_EV_FAULT 2
`define LDPWM_EV_W 3

// Timing figures and derived cycle counts at 10 MHz.
`define LDPWM_CLK_HZ 10000000
`define LDPWM_MIN_PERIOD_US 1000
`define LDPWM_MIN_PERIOD_CYC ((`LDPWM_MIN_PERIOD_US * (`LDPWM_CLK_HZ / 1000000)))
`define LDPWM_MIN_HIGH_US 6
`define LDPWM_MIN_HIGH_CYC ((`LDPWM_MIN_HIGH_US * (`LDPWM_CLK_HZ / 1000000)))

// Engine period slope: ns per ohm times ten (7.4e-8 and 7.4e-7 s/ohm).
`define LDPWM_SLOPE_HR_NS_X10 740
`define LDPWM_SLOPE_LR_NS_X10 7400
// Range bounds in ohms.
`define LDPWM_HR_MIN_OHM 18000
`define LDPWM_HR_MAX_OHM 90000
`define LDPWM_LR_MIN_OHM 1800
`define LDPWM_LR_MAX_OHM 9000

// Duty resolution and full scale.
`define LDPWM_DUTY_BITS 10
`define LDPWM_DUTY_FULL 10'h3ff

// Fault report duty patterns in high range, in sixteenths of a period.
`define LDPWM_FLT_DUTY_S2G 4'h4
`define LDPWM_FLT_DUTY_OV 4'h8
`define LDPWM_FLT_DUTY_OT 4'hc
`define LDPWM_FLT_DUTY_OC 4'he

`endif

// [logic/ldpwm_top.v]
// LED dimming PWM control: digital pattern check and embedded engine.
// Assumes the dimming level arrives quantised with comparator flags from
// an analog front end, and fault flags come from protection logic.
//
// Contract
// [R1] Accept digital PWM only on full-swing, slow, fault-free input.
// [R2] Valid pattern and high input: gate and switch on.
// [R3] Source holds each high pulse at least 6 us.
// [R4] Engine runs only between zero and full thresholds.
// [R5] Duty rises linearly with quantised level.
// [R6] Engine toggles load switch with generated waveform.
// [R7] Any fault stops engine, switch forced off.
// [R8] Period scales with resistance, range-dependent factor.
// [R9] High range: each fault has own duty.
// [R10] Low range: fault pin held while fault.
// [R11] High range: voltage loop off, comparator on.
// [R12] Low range: voltage loop enabled with current loop.
// [R13] Above high: full duty; below low: zero.
// [R14] Engine thresholds 1 V and 3.6 V.
// [R15] Duty quantised to 10 bits.
// [R16] Range classes 18-90 kohm, 1.8-9 kohm.
// [R17] Range sampled once after reset, then held.
// [R18] Reject pattern when any period below 1 ms.
//
// The register addresses and register access over APB were decided locally.
`include "ldpwm_defs.vh"
`default_nettype none

module ldpwm_top #(
    parameter MIN_PERIOD_CYC = `LDPWM_MIN_PERIOD_CYC,
    parameter integer RES_W = 17
) (
    input wire clock, // System clock, 10 MHz.
    input wire nrst, // Asynchronous reset, active low.
    input wire psel, // APB select.
    input wire penable, // APB enable.
    input wire pwrite, // APB direction.
    input wire [11:0] paddr, // APB byte address.
    input wire [31:0] pwdata, // APB write data.
    output wire [31:0] prdata, // APB read data.
    output wire pready, // APB ready.
    output wire pslverr, // APB error on unmapped address.
    output wire irq, // Level interrupt.
    input wire dimming_input, // Digital dimming pin level.
    input wire dim_above_high, // Level above dim_high_threshold.
    input wire dim_below_low, // Level below dim_low_threshold.
    input wire [9:0] dim_level, // Quantised level between 1 V and 3.6 V.
    input wire [16:0] prog_resistance, // Programming resistance in ohms.
    input wire [3:0] fault_flags, // Short, overvoltage, overtemp, overcurrent.
    output reg load_switch_gate_out, // High drives gate_on_level.
    output reg switch_driver_en, // Switching gate driver enable.
    output reg freq_set_fault_pin, // Fault report level.
    output reg volt_loop_en, // Voltage regulation loop enable.
    output reg ov_comparator_en // Overvoltage comparator enable.
);

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers: three stages, change accepted when two agree.
    reg [2:0] din_sync_ff, hi_sync_ff, lo_sync_ff;
    reg din_ff, hi_ff, lo_ff;
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            din_sync_ff <= 3'h0;
            hi_sync_ff <= 3'h0;
            lo_sync_ff <= 3'h0;
            din_ff <= 1'b0;
            hi_ff <= 1'b0;
            lo_ff <= 1'b0;
        end else begin
            din_sync_ff <= {din_sync_ff[1:0], dimming_input};
            hi_sync_ff <= {hi_sync_ff[1:0], dim_above_high};
            lo_sync_ff <= {lo_sync_ff[1:0], dim_below_low};
            if (din_sync_ff[1] == din_sync_ff[2]) din_ff <= din_sync_ff[2];
            if (hi_sync_ff[1] == hi_sync_ff[2]) hi_ff <= hi_sync_ff[2];
            if (lo_sync_ff[1] == lo_sync_ff[2]) lo_ff <= lo_sync_ff[2];
        end
    end

    wire fault_any = |fault_flags;

    ////////////////////////////////////////////////////////////////////////
    // Registers.
    reg [31:0] ctrl_ff;
    reg [2:0] irq_ff, mask_ff;
    reg range_done_ff, high_range_ff, range_valid_ff;
    reg [31:0] period_ff;
    reg [9:0] duty_ff;
    reg dig_valid_ff;

    // Range sampled once after reset release, period derived from it.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            range_done_ff <= 1'b0;
            high_range_ff <= 1'b0;
            range_valid_ff <= 1'b0;
            period_ff <= 32'h0000_0001;
        end else if (!range_done_ff) begin // [R17]
            range_done_ff <= 1'b1;
            high_range_ff <= (prog_resistance >= `LDPWM_HR_MIN_OHM) &&
                (prog_resistance <= `LDPWM_HR_MAX_OHM); // [R16]
            range_valid_ff <= ((prog_resistance >= `LDPWM_HR_MIN_OHM) &&
                (prog_resistance <= `LDPWM_HR_MAX_OHM)) ||
                ((prog_resistance >= `LDPWM_LR_MIN_OHM) &&
                (prog_resistance <= `LDPWM_LR_MAX_OHM)); // [R16]
            // Period in 100 ns cycles = R * slope_ns / 100. [R8]
            if (prog_resistance >= `LDPWM_HR_MIN_OHM)
                period_ff <= ({15'h0, prog_resistance} *
                    `LDPWM_SLOPE_HR_NS_X10) / 1000;
            else
                period_ff <= ({15'h0, prog_resistance} *
                    `LDPWM_SLOPE_LR_NS_X10) / 1000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Digital pattern check: period counter; the high time is not counted.
    reg [31:0] per_cnt_ff;
    reg din_d_ff, seen_low_ff, seen_high_ff;
    wire rise = din_ff && !din_d_ff;
    wire dig_set = rise && seen_low_ff && seen_high_ff && !fault_any &&
        (per_cnt_ff >= MIN_PERIOD_CYC - 1);
    wire dig_rej = rise && dig_valid_ff && (per_cnt_ff < MIN_PERIOD_CYC - 1);
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            per_cnt_ff <= 32'h0;
            din_d_ff <= 1'b0;
            seen_low_ff <= 1'b0;
            seen_high_ff <= 1'b0;
            dig_valid_ff <= 1'b0;
        end else begin
            din_d_ff <= din_ff;
            if (lo_ff) seen_low_ff <= 1'b1; // [R1]
            if (hi_ff) seen_high_ff <= 1'b1; // [R1]
            if (rise) begin
                per_cnt_ff <= 32'h0;
                seen_low_ff <= lo_ff;
                seen_high_ff <= hi_ff;
            end else if (per_cnt_ff != 32'hffff_ffff)
                per_cnt_ff <= per_cnt_ff + 32'h1;
            // Fault, short period or a cleared digital enable bit drops the pattern.
            if (fault_any || dig_rej || !ctrl_ff[`LDPWM_CTRL_DIG_EN])
                dig_valid_ff <= 1'b0; // [R1] [R18]
            else if (dig_set)
                dig_valid_ff <= 1'b1; // [R1]
            else if (!din_ff && per_cnt_ff >= 32'hffff_fff0)
                dig_valid_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Embedded engine: counter compared against quantised duty.
    reg [31:0] eng_cnt_ff;
    wire emb_zone = !hi_ff && !lo_ff; // [R4] [R14]
    wire emb_en = emb_zone && !fault_any && !dig_valid_ff &&
        ctrl_ff[`LDPWM_CTRL_EMB_EN]; // [R4] [R7]
    // Scale the 10-bit duty onto the period: linear from zero to 1023/1024 of the period.
    wire [41:0] on_prod = period_ff * {22'h0, duty_ff}; // [R5]
    wire [31:0] on_cyc = on_prod[41:10];
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            eng_cnt_ff <= 32'h0;
            duty_ff <= 10'h000;
        end else begin
            duty_ff <= dim_level; // [R15]
            // The counter keeps running through a fault so that the fault
            // pin can be timed against it; the switch is held off meanwhile.
            if ((!emb_en && !fault_any) || eng_cnt_ff + 32'h1 >= period_ff)
                eng_cnt_ff <= 32'h0; // [R8] [R9]
            else
                eng_cnt_ff <= eng_cnt_ff + 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output selection between digital, static and embedded modes.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            load_switch_gate_out <= 1'b0;
            switch_driver_en <= 1'b0;
        end else if (fault_any) begin
            load_switch_gate_out <= 1'b0; // [R7]
            switch_driver_en <= 1'b0;
        end else if (dig_valid_ff) begin
            load_switch_gate_out <= din_ff && hi_ff; // [R2]
            switch_driver_en <= din_ff && hi_ff; // [R2]
        end else if (hi_ff) begin
            load_switch_gate_out <= 1'b1; // [R13]
            switch_driver_en <= 1'b1;
        end else if (lo_ff || !emb_en) begin
            load_switch_gate_out <= 1'b0; // [R13]
            switch_driver_en <= 1'b0;
        end else begin
            load_switch_gate_out <= eng_cnt_ff < on_cyc; // [R6]
            switch_driver_en <= eng_cnt_ff < on_cyc; // [R6]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fault reporting and loop selection by range.
    reg [3:0] flt_duty;
    always @* begin
        flt_duty = 4'h0;
        if (fault_flags[0]) flt_duty = `LDPWM_FLT_DUTY_S2G;
        else if (fault_flags[1]) flt_duty = `LDPWM_FLT_DUTY_OV;
        else if (fault_flags[2]) flt_duty = `LDPWM_FLT_DUTY_OT;
        else if (fault_flags[3]) flt_duty = `LDPWM_FLT_DUTY_OC;
    end
    wire [35:0] flt_prod = period_ff * {28'h0, flt_duty};
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            freq_set_fault_pin <= 1'b0;
            volt_loop_en <= 1'b0;
            ov_comparator_en <= 1'b0;
        end else begin
            volt_loop_en <= range_done_ff && !high_range_ff; // [R12]
            ov_comparator_en <= range_done_ff && high_range_ff; // [R11]
            if (!fault_any)
                freq_set_fault_pin <= 1'b0;
            else if (high_range_ff)
                freq_set_fault_pin <= eng_cnt_ff < flt_prod[35:4]; // [R9]
            else
                freq_set_fault_pin <= 1'b1; // [R10]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt events: valid pattern, rejected pattern, fault rise.
    reg fault_d_ff;
    wire [2:0] ev = {fault_any && !fault_d_ff, dig_rej, dig_set};
    wire wr = psel && penable && pwrite;
    wire rd_map = (paddr == `LDPWM_ADDR_CTRL) ||
        (paddr == `LDPWM_ADDR_STAT) || (paddr == `LDPWM_ADDR_IRQ) ||
        (paddr == `LDPWM_ADDR_MASK) || (paddr == `LDPWM_ADDR_RES) ||
        (paddr == `LDPWM_ADDR_DUTY);
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ctrl_ff <= `LDPWM_CTRL_RESET;
            irq_ff <= 3'h0;
            mask_ff <= 3'h0;
            fault_d_ff <= 1'b0;
        end else begin
            fault_d_ff <= fault_any;
            // Set wins over a write-one clear in the same cycle.
            if (wr && paddr == `LDPWM_ADDR_IRQ)
                irq_ff <= (irq_ff & ~pwdata[2:0]) | ev;
            else
                irq_ff <= irq_ff | ev;
            if (wr && paddr == `LDPWM_ADDR_MASK) mask_ff <= pwdata[2:0];
            if (wr && paddr == `LDPWM_ADDR_CTRL)
                ctrl_ff <= {30'h0, pwdata[1:0]};
        end
    end
    assign irq = |(irq_ff & mask_ff);

    ////////////////////////////////////////////////////////////////////////
    // APB read mux, zero-wait answer.
    reg [31:0] rdata;
    always @* begin
        rdata = 32'h0;
        case (paddr)
            `LDPWM_ADDR_CTRL: rdata = ctrl_ff;
            `LDPWM_ADDR_STAT: rdata = {24'h0, range_valid_ff, high_range_ff,
                fault_any, emb_en, dig_valid_ff, load_switch_gate_out,
                freq_set_fault_pin, volt_loop_en};
            `LDPWM_ADDR_IRQ: rdata = {29'h0, irq_ff};
            `LDPWM_ADDR_MASK: rdata = {29'h0, mask_ff};
            `LDPWM_ADDR_RES: rdata = {15'h0, prog_resistance};
            `LDPWM_ADDR_DUTY: rdata = {22'h0, duty_ff};
            default: rdata = 32'h0;
        endcase
    end
    assign prdata = rdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !rd_map;

endmodule // ldpwm_top
`default_nettype wire

// [testbench/ldpwm_top_chk.sv]
// Checker for the LED dimming PWM control block.
// Assumes a bind to ldpwm_top; it sees only that module's ports.
`default_nettype none
////////////////////////////////////////////////////////////////////////////
module ldpwm_top_chk #(
    parameter MIN_PERIOD_CYC = 10000
) (
    input wire logic clock, // System clock.
    input wire logic nrst, // Reset, active low.
    input wire logic dim_above_high, // Level above high threshold.
    input wire logic dim_below_low, // Level below low threshold.
    input wire logic [16:0] prog_resistance, // Resistance in ohms.
    input wire logic [3:0] fault_flags, // Active faults.
    input wire logic load_switch_gate_out, // Load switch gate.
    input wire logic switch_driver_en, // Switching driver enable.
    input wire logic freq_set_fault_pin, // Fault report pin.
    input wire logic volt_loop_en, // Voltage loop enable.
    input wire logic ov_comparator_en // Overvoltage comparator enable.
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] cyc_ff;
    logic hr;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    // Counts edges after reset, so range outputs are judged once settled.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cyc_ff <= 2'h0;
        end else if (cyc_ff != 2'h3) begin
            cyc_ff <= cyc_ff + 2'h1;
        end
    end
    // High range is 18000 to 90000 ohm.
    assign hr = prog_resistance >= 17'h4650 && prog_resistance <= 17'h15f90;
    sequence s_fault_held;
        (fault_flags != 4'h0) [*4];
    endsequence
    sequence s_low_held;
        (dim_below_low && !dim_above_high) [*8];
    endsequence
    sequence s_high_held;
        (dim_above_high && fault_flags == 4'h0) [*8];
    endsequence
    a_fault_gate_off: assert property (
        fault_flags != 4'h0 |=> !load_switch_gate_out)
        else $error("load switch on after a fault");
    a_fault_drv_off: assert property (
        fault_flags != 4'h0 |=> !switch_driver_en)
        else $error("switching driver on after a fault");
    a_hr_loops: assert property (
        cyc_ff == 2'h3 && hr |-> !volt_loop_en && ov_comparator_en)
        else $error("high range loop setting wrong");
    a_lr_loops: assert property (
        cyc_ff == 2'h3 && !hr |-> volt_loop_en && !ov_comparator_en)
        else $error("low range loop setting wrong");
    a_range_held: assert property (
        cyc_ff == 2'h3 |-> $stable({volt_loop_en, ov_comparator_en}))
        else $error("range decode changed in operation");
    a_lr_fault_pin: assert property (
        s_fault_held ##0 (cyc_ff == 2'h3 && !hr) |-> freq_set_fault_pin)
        else $error("fault pin low during a low range fault");
    a_low_gate_off: assert property (
        s_low_held |-> !load_switch_gate_out && !switch_driver_en)
        else $error("output on with a low input");
    a_high_gate_on: assert property (
        s_high_held |-> load_switch_gate_out && switch_driver_en)
        else $error("output off with a high input");
endmodule // ldpwm_top_chk
`default_nettype wire

// [testbench/ldpwm_dim_src.sv]
// Dimming source model: a pulse train or a static level.
// Assumes the block's clock; the pin has a pull-down when released.
`default_nettype none
////////////////////////////////////////////////////////////////////////////
module ldpwm_dim_src (
    input wire logic clock, // System clock.
    input wire logic run, // High sends a pulse train.
    input wire logic [1:0] idle_mode, // Static: 0 low, 1 high, 2 mid.
    input wire logic [15:0] period, // Cycles per period.
    input wire logic [15:0] high_len, // High cycles per period.
    output logic dimming_input, // Digital pin level.
    output logic dim_above_high, // Above high threshold.
    output logic dim_below_low // Below low threshold.
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] cnt_ff;
    logic hi;
    // Period counter, held at zero while no train is sent.
    always @(posedge clock) begin
        cnt_ff <= (!run || cnt_ff + 16'h1 >= period) ? 16'h0 : cnt_ff + 16'h1;
    end
    // Full-swing pulses; high_len of 60 or more keeps 6 us high.
    assign hi = run ? cnt_ff < high_len : idle_mode == 2'h1;
    assign dimming_input = hi;
    assign dim_above_high = hi;
    assign dim_below_low = run ? !hi : idle_mode == 2'h0;
endmodule // ldpwm_dim_src
`default_nettype wire

// [testbench/tb_led_dimming_pwm_control.sv]
// Testbench for the LED dimming PWM control block.
// Assumes the design, source model and checker are compiled first.
`include "ldpwm_defs.vh"
`default_nettype none
////////////////////////////////////////////////////////////////////////////
module tb_led_dimming_pwm_control;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock, psel = 0, penable = 0, pwrite = 0, nrst = 0, run = 0;
    logic din, above, below, pready, pslverr, irq, gate, drv, fpin, vl, ovc;
    logic last_err;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [9:0] dim_level = 10'h200;
    logic [16:0] prog_res = 17'h4e20;
    logic [3:0] fault_flags = 4'h0;
    logic [1:0] idle_mode = 2'h2;
    logic [15:0] period = 16'd200, high_len = 16'd100;
    int n_fail = 0, n_tests = 0, n_hi;
    // Engine period in cycles: 18000 ohm at 0.74 cycles per ohm, or
    // 1800 ohm at 7.4 cycles per ohm, both 13320.
    localparam int ENG_P = 13320;
    ldpwm_top #(.MIN_PERIOD_CYC(100)) DUT (.clock(clock), .nrst(nrst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq(irq), .dimming_input(din), .dim_above_high(above),
        .dim_below_low(below), .dim_level(dim_level),
        .prog_resistance(prog_res), .fault_flags(fault_flags),
        .load_switch_gate_out(gate), .switch_driver_en(drv),
        .freq_set_fault_pin(fpin), .volt_loop_en(vl), .ov_comparator_en(ovc));
    ldpwm_dim_src u_src (.clock(clock), .run(run), .idle_mode(idle_mode),
        .period(period), .high_len(high_len), .dimming_input(din),
        .dim_above_high(above), .dim_below_low(below));
    // Clock of 100 ns period.
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // Prints the counts and the verdict, then stops.
    task conclude;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task chkn(input int got, input int exp, input int tol, input string m);
        n_tests++;
        if (got > exp + tol || got < exp - tol) begin
            n_fail++;
            $display("BAD t=%0t %s got %0d exp %0d", $time, m, got, exp);
        end
    endtask
    // One APB transfer; read data and error are taken at the ready edge.
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
        if (n >= 20) begin
            n_fail++;
            $display("BAD t=%0t no ready", $time);
            conclude;
        end
    endtask
    // Holds reset for five cycles; resistance is set only while in reset.
    // Range outputs are valid from the second edge after release, so the
    // task returns one edge after that, when they have settled.
    task do_reset(input logic [16:0] r);
        nrst <= 1'b0;
        prog_res <= r;
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        repeat (3) @(posedge clock);
    endtask
    // Finds a rising edge of the load switch, then for each of n levels
    // sets the level on the next clock edge and measures the one period after it.
    // The switch is sampled on the falling edge, where it has settled.
    task measure(input int p, input int lvl, input int n);
        int k, hi, len;
        logic prev;
        prev = 1'b1;
        for (k = 0; k < 2 * p && !(prev === 1'b0 && gate === 1'b1); k++) begin
            prev = gate;
            @(negedge clock);
        end
        if (k >= 2 * p) begin
            n_fail++;
            $display("BAD t=%0t no engine edge", $time);
        end
        for (int i = 1; i <= n; i++) begin
            @(posedge clock);
            dim_level <= 10'(i * lvl);
            hi = 1;
            len = 1;
            prev = 1'b1;
            @(negedge clock);
            while (!(prev === 1'b0 && gate === 1'b1) && len < 2 * p) begin
                hi += (gate === 1'b1);
                len++;
                prev = gate;
                @(negedge clock);
            end
            chkn(len, p, 4, "engine period");
            chkn(hi, p * i * lvl / 1024, 8, "engine duty");
        end
        @(posedge clock);
    endtask
    // Main sequence: registers, engine, faults, digital pattern.
    initial begin
        do_reset(17'h4650);
        apb(1'b0, `LDPWM_ADDR_CTRL, 32'h0);
        chk(rd, `LDPWM_CTRL_RESET, "ctrl reset");
        apb(1'b1, `LDPWM_ADDR_RES, 32'h5);
        apb(1'b0, `LDPWM_ADDR_RES, 32'h0);
        chk(rd, 32'h4650, "resistance");
        apb(1'b0, 12'h020, 32'h0);
        chk({rd[30:0], last_err}, 32'h1, "unmapped");
        chk({30'h0, vl, ovc}, 32'h1, "high range loops");
        measure(ENG_P, 256, 3);
        apb(1'b0, `LDPWM_ADDR_DUTY, 32'h0);
        chk(rd, 32'h300, "duty level");
        apb(1'b1, `LDPWM_ADDR_MASK, 32'h7);
        fault_flags <= 4'h2;
        repeat (20) @(posedge clock);
        chk({30'h0, gate, irq}, 32'h1, "fault stop");
        n_hi = 0;
        for (int k = 0; k < ENG_P; k++) begin
            @(negedge clock);
            n_hi += (fpin === 1'b1);
        end
        @(posedge clock);
        chkn(n_hi, ENG_P * `LDPWM_FLT_DUTY_OV / 16, 4, "fault duty");
        fault_flags <= 4'h0;
        apb(1'b0, `LDPWM_ADDR_IRQ, 32'h0);
        chk(rd, 32'h1 << `LDPWM_EV_FAULT, "fault event");
        apb(1'b1, `LDPWM_ADDR_IRQ, rd);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        idle_mode <= 2'h1;
        repeat (20) @(posedge clock);
        chk({31'h0, gate}, 32'h1, "full on");
        idle_mode <= 2'h0;
        repeat (20) @(posedge clock);
        chk({31'h0, gate}, 32'h0, "full off");
        $display("test high range done");
        do_reset(17'h708);
        chk({30'h0, vl, ovc}, 32'h2, "low range loops");
        idle_mode <= 2'h2;
        measure(ENG_P, 512, 1);
        fault_flags <= 4'h4;
        repeat (10) @(posedge clock);
        chk({31'h0, fpin}, 32'h1, "steady fault pin");
        fault_flags <= 4'h0;
        $display("test low range done");
        do_reset(17'h4e20);
        apb(1'b1, `LDPWM_ADDR_MASK, 32'h7);
        run <= 1'b1;
        repeat (1000) @(posedge clock);
        apb(1'b0, `LDPWM_ADDR_IRQ, 32'h0);
        chk({rd[29:0], 1'b0, irq}, 32'h5, "valid pattern");
        apb(1'b1, `LDPWM_ADDR_IRQ, 32'h1);
        period <= 16'd90;
        high_len <= 16'd60;
        repeat (500) @(posedge clock);
        apb(1'b1, `LDPWM_ADDR_MASK, 32'h0);
        apb(1'b0, `LDPWM_ADDR_IRQ, 32'h0);
        chk({rd[1], irq}, 32'h2, "short period");
        period <= 16'd200;
        fault_flags <= 4'h8;
        repeat (300) @(posedge clock);
        apb(1'b1, `LDPWM_ADDR_IRQ, 32'h7);
        repeat (1200) @(posedge clock);
        apb(1'b0, `LDPWM_ADDR_IRQ, 32'h0);
        chk(rd, 32'h0, "no accept in fault");
        fault_flags <= 4'h0;
        repeat (1000) @(posedge clock);
        apb(1'b0, `LDPWM_ADDR_IRQ, 32'h0);
        chk(rd, 32'h1, "accept after fault");
        $display("test digital done");
        conclude;
    end
endmodule // tb_led_dimming_pwm_control
bind ldpwm_top ldpwm_top_chk #(.MIN_PERIOD_CYC(MIN_PERIOD_CYC)) u_chk (
    .clock(clock), .nrst(nrst), .dim_above_high(dim_above_high),
    .dim_below_low(dim_below_low), .prog_resistance(prog_resistance),
    .fault_flags(fault_flags), .load_switch_gate_out(load_switch_gate_out),
    .switch_driver_en(switch_driver_en), .freq_set_fault_pin(freq_set_fault_pin),
    .volt_loop_en(volt_loop_en), .ov_comparator_en(ov_comparator_en));
`default_nettype wire
